// ==== design/asr_pkg.sv ====
package asr_pkg;

  localparam int REF_CLK_MHZ = 250;
  localparam int ANGLE_REFRESH_NS = 1000;
  localparam int ANGLE_TICK_CYCLES = ANGLE_REFRESH_NS * REF_CLK_MHZ / 1000;
  localparam int NONVOLATILE_WRITE_WAIT_MS = 20;
  localparam int NONVOLATILE_WRITE_WAIT_CYCLES = NONVOLATILE_WRITE_WAIT_MS * 1000 * REF_CLK_MHZ;
  localparam int TRANSFER_TIMEOUT_US = 25;
  localparam int TRANSFER_TIMEOUT_CYCLES = TRANSFER_TIMEOUT_US * REF_CLK_MHZ;
  // Gap times that the master keeps; listed for the bench, not enforced here.
  localparam int ANGLE_GAP_TIME_NS = 150;
  localparam int REGISTER_GAP_TIME_NS = 750;
  localparam int FRAME_DEAD_TIME_US = 40;

  localparam int FRAME_BITS = 16;
  localparam int SSI_MAX_PULSES = 17;
  localparam int ANGLE_USEFUL_BITS = 12;

  localparam logic [2:0] OPCODE_READ = 3'h2;
  localparam logic [2:0] OPCODE_WRITE = 3'h4;
  localparam int OPCODE_MSB = 15;
  localparam int ADDR_MSB = 12;
  localparam int DATA_MSB = 7;

  localparam logic [4:0] STATUS_ADDR = 5'h1b;
  localparam int FIELD_HIGH_BIT = 7;
  localparam int FIELD_LOW_BIT = 6;
  localparam logic [4:0] DIRECTION_ADDR = 5'h09;
  localparam int DIRECTION_BIT = 7;
  localparam logic DIRECTION_RESET = 1'b0;

  localparam logic [7:0] RESET_VALUE_REG4 = 8'hc0;
  localparam logic [7:0] RESET_VALUE_REG5 = 8'h0f;
  localparam logic [7:0] RESET_VALUE_REG6 = 8'h1c;

  typedef enum logic {REPLY_ANGLE, REPLY_REGISTER} asr_reply_t;

  // Factory content of the nonvolatile store.
  function automatic logic [7:0] asrFactoryValue(input logic [4:0] addr);
    case (addr)
      5'h04: asrFactoryValue = RESET_VALUE_REG4;
      5'h05: asrFactoryValue = RESET_VALUE_REG5;
      5'h06: asrFactoryValue = RESET_VALUE_REG6;
      default: asrFactoryValue = 8'h00;
    endcase
  endfunction

  // Picks the next serial bit after pos bits were sent; zero past the end of the word.
  function automatic logic asrPickBit(input logic [15:0] word, input logic [4:0] pos);
    if (pos < 5'(FRAME_BITS))
      asrPickBit = word[4'(15 - pos)];
    else
      asrPickBit = 1'b0;
  endfunction

endpackage

// ==== design/asr_reg_mem.sv ====
`timescale 1ns/1ps
module asr_reg_mem
  import asr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [4:0] rdAddr,
  output logic [7:0] rdData_q
);

  logic [7:0] mem_q [32];

  // The store comes up holding the factory content at power-on.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 32; i++)
      begin
        mem_q[i] <= asrFactoryValue(5'(i));
      end
    end
    else if (wrEn)
    begin
      mem_q[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData_q <= 8'h00;
    else
      rdData_q <= mem_q[rdAddr];
  end

endmodule

// ==== design/asr_serial_readout.sv ====
`timescale 1ns/1ps
module asr_serial_readout
  import asr_pkg::*;
#(
  parameter int unsigned NVM_WAIT_CYCLES = NONVOLATILE_WRITE_WAIT_CYCLES,
  parameter int unsigned TIMEOUT_CYCLES = TRANSFER_TIMEOUT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] frontAngle,
  input wire logic fieldHighFlag,
  input wire logic fieldLowFlag,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic serialAngleClock,
  output logic serialAngleOut,
  output logic rotationCcw
);

  // Link side, clocked by the master's serial clock.
  logic linkRst;
  logic [4:0] rxCount_q;
  logic [15:0] rxShift_q;
  logic [15:0] rxFrame_q;
  logic frameToggle_q;
  logic txBit_q;
  logic txStarted_q;

  // Word offered to the link; only changes while select is idle.
  logic [15:0] txWord_q;

  // Ref clock side.
  logic csMeta_q;
  logic csIdle_q;
  logic togMeta_q;
  logic togSync_q;
  logic togPrev_q;
  logic frameEvent;
  logic [7:0] tickCount_q;
  logic tick;
  logic [15:0] angleBuf_q;
  logic frozen;
  asr_reply_t replyMode_q;
  logic [4:0] replyAddr_q;
  logic [2:0] opcode;
  logic wrBusy_q;
  logic [4:0] wrAddr_q;
  logic [7:0] wrData_q;
  logic [22:0] wrTimer_q;
  logic wrCommit;
  logic [7:0] memData;
  logic fieldHigh_q;
  logic fieldLow_q;
  logic [7:0] regValue;
  logic ssiMeta_q;
  logic ssiSync_q;
  logic ssiPrev_q;
  logic ssiRise;
  logic ssiFall;
  logic ssiBusy_q;
  logic [4:0] ssiCount_q;
  logic [12:0] ssiTimer_q;

  // Select high clears the frame state, so a cut frame leaves nothing behind.
  assign linkRst = spiCsN | ~reset_n;

  always_ff @(posedge spiSclk or posedge linkRst)
  begin
    if (linkRst)
    begin
      rxCount_q <= 5'h00;
      rxShift_q <= 16'h0000;
    end
    else
    begin
      rxShift_q <= {rxShift_q[14:0], spiMosi};
      if (rxCount_q < 5'(FRAME_BITS))
        rxCount_q <= rxCount_q + 5'h01;
    end
  end

  // Only a complete sixteenth bit hands a command to the ref clock side.
  always_ff @(posedge spiSclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxFrame_q <= 16'h0000;
      frameToggle_q <= 1'b0;
    end
    else if (!spiCsN && rxCount_q == 5'(FRAME_BITS - 1))
    begin
      rxFrame_q <= {rxShift_q[14:0], spiMosi};
      frameToggle_q <= ~frameToggle_q;
    end
  end

  // Falling edges shift out the next bit. In mode 3 the first falling edge comes
  // before any rising edge and presents the MSB; in mode 0 the MSB is already
  // on the line from select low, so no mode setting is needed.
  always_ff @(negedge spiSclk or posedge linkRst)
  begin
    if (linkRst)
    begin
      txBit_q <= 1'b0;
      txStarted_q <= 1'b0;
    end
    else
    begin
      txBit_q <= asrPickBit(txWord_q, rxCount_q);
      txStarted_q <= 1'b1;
    end
  end

  // Until the first falling edge the MSB is driven straight from the held word.
  assign spiMiso = txStarted_q ? txBit_q : txWord_q[15];
  assign spiMisoOe = ~spiCsN;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csMeta_q <= 1'b1;
      csIdle_q <= 1'b1;
    end
    else
    begin
      csMeta_q <= spiCsN;
      csIdle_q <= csMeta_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      togMeta_q <= 1'b0;
      togSync_q <= 1'b0;
      togPrev_q <= 1'b0;
    end
    else
    begin
      togMeta_q <= frameToggle_q;
      togSync_q <= togMeta_q;
      togPrev_q <= togSync_q;
    end
  end

  assign frameEvent = togSync_q ^ togPrev_q;
  // The frame register is stable for sixteen link clocks after each toggle.
  assign opcode = rxFrame_q[OPCODE_MSB -: 3];

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tickCount_q <= 8'h00;
    else if (tick)
      tickCount_q <= 8'h00;
    else
      tickCount_q <= tickCount_q + 8'h01;
  end

  assign tick = tickCount_q == 8'(ANGLE_TICK_CYCLES - 1);
  assign frozen = ~csIdle_q | ssiBusy_q;

  // Direction is applied by negating the raw angle, then unused low bits are cleared.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      angleBuf_q <= 16'h0000;
    else if (tick && !frozen)
    begin
      if (rotationCcw)
        angleBuf_q <= (16'h0000 - frontAngle) & ~16'((1 << (FRAME_BITS - ANGLE_USEFUL_BITS)) - 1);
      else
        angleBuf_q <= frontAngle & ~16'((1 << (FRAME_BITS - ANGLE_USEFUL_BITS)) - 1);
    end
  end

  // Each complete frame decides what the next frame returns.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      replyMode_q <= REPLY_ANGLE;
      replyAddr_q <= 5'h00;
    end
    else if (frameEvent)
    begin
      case (opcode)
        OPCODE_READ:
        begin
          replyMode_q <= REPLY_REGISTER;
          replyAddr_q <= rxFrame_q[ADDR_MSB -: 5];
        end
        OPCODE_WRITE:
        begin
          replyMode_q <= REPLY_REGISTER;
          replyAddr_q <= rxFrame_q[ADDR_MSB -: 5];
        end
        default:
        begin
          replyMode_q <= REPLY_ANGLE;
          replyAddr_q <= replyAddr_q;
        end
      endcase
    end
  end

  // A write is held back for the programming time; a new write while one is
  // pending is dropped.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrBusy_q <= 1'b0;
      wrAddr_q <= 5'h00;
      wrData_q <= 8'h00;
      wrTimer_q <= 23'h000000;
    end
    else if (wrBusy_q)
    begin
      wrTimer_q <= wrTimer_q + 23'h000001;
      if (wrCommit)
        wrBusy_q <= 1'b0;
    end
    else if (frameEvent && opcode == OPCODE_WRITE)
    begin
      wrBusy_q <= 1'b1;
      wrAddr_q <= rxFrame_q[ADDR_MSB -: 5];
      wrData_q <= rxFrame_q[DATA_MSB:0];
      wrTimer_q <= 23'h000000;
    end
  end

  assign wrCommit = wrBusy_q && wrTimer_q == 23'(NVM_WAIT_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rotationCcw <= DIRECTION_RESET;
    else if (wrCommit && wrAddr_q == DIRECTION_ADDR)
      rotationCcw <= wrData_q[DIRECTION_BIT];
  end

  asr_reg_mem u_reg_mem (
    .clk(ref_clk),
    .reset_n(reset_n),
    .wrEn(wrCommit),
    .wrAddr(wrAddr_q),
    .wrData(wrData_q),
    .rdAddr(replyAddr_q),
    .rdData_q(memData)
  );

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fieldHigh_q <= 1'b0;
      fieldLow_q <= 1'b0;
    end
    else
    begin
      fieldHigh_q <= fieldHighFlag;
      fieldLow_q <= fieldLowFlag;
    end
  end

  always_comb
  begin
    regValue = memData;
    if (replyAddr_q == STATUS_ADDR)
    begin
      regValue = 8'h00;
      regValue[FIELD_HIGH_BIT] = fieldHigh_q;
      regValue[FIELD_LOW_BIT] = fieldLow_q;
    end
  end

  // The link reads this word only while select is low, when it stands still.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      txWord_q <= 16'h0000;
    else if (csIdle_q && !frameEvent)
    begin
      if (replyMode_q == REPLY_REGISTER)
        txWord_q <= {regValue, 8'h00};
      else
        txWord_q <= angleBuf_q;
    end
  end

  // The two-wire port is slow enough to be sampled on the ref clock.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ssiMeta_q <= 1'b0;
      ssiSync_q <= 1'b0;
      ssiPrev_q <= 1'b0;
    end
    else
    begin
      ssiMeta_q <= serialAngleClock;
      ssiSync_q <= ssiMeta_q;
      ssiPrev_q <= ssiSync_q;
    end
  end

  assign ssiRise = ssiSync_q & ~ssiPrev_q;
  assign ssiFall = ~ssiSync_q & ssiPrev_q;

  // The timeout restarts on every clock edge, so the buffer is released one
  // timeout after the last falling edge, whether the read was full or short.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ssiBusy_q <= 1'b0;
      ssiCount_q <= 5'h00;
      ssiTimer_q <= 13'h0000;
      serialAngleOut <= 1'b0;
    end
    else if (ssiRise)
    begin
      ssiTimer_q <= 13'(TIMEOUT_CYCLES);
      if (!ssiBusy_q)
      begin
        ssiBusy_q <= 1'b1;
        ssiCount_q <= 5'h01;
      end
      else
      begin
        if (ssiCount_q < 5'(SSI_MAX_PULSES))
          ssiCount_q <= ssiCount_q + 5'h01;
        serialAngleOut <= asrPickBit(angleBuf_q, ssiCount_q - 5'h01);
      end
    end
    else if (ssiFall)
    begin
      ssiTimer_q <= 13'(TIMEOUT_CYCLES);
    end
    else if (ssiBusy_q)
    begin
      if (ssiTimer_q <= 13'h0001)
      begin
        ssiBusy_q <= 1'b0;
        ssiCount_q <= 5'h00;
        ssiTimer_q <= 13'h0000;
        serialAngleOut <= 1'b0;
      end
      else
      begin
        ssiTimer_q <= ssiTimer_q - 13'h0001;
      end
    end
  end

endmodule

// ==== tb/asr_serial_readout_props.sv ====
`timescale 1ns/1ps
module asr_serial_readout_props
  import asr_pkg::*;
#(
  parameter int unsigned NVM_WAIT_CYCLES = 200,
  parameter int unsigned TIMEOUT_CYCLES = 100
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] frontAngle,
  input wire logic fieldHighFlag,
  input wire logic fieldLowFlag,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic serialAngleClock,
  input wire logic serialAngleOut,
  input wire logic rotationCcw
);
  logic sckQ, csQ, ssiQ;
  int unsigned sinceFall, sinceCs, sinceRise, idleCnt, ssiCnt;
  // Edge ages restart one ref clock edge after a pin moves, so the edge that
  // first sees the move is covered by the sampled-value functions instead.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sckQ <= 1'b0;
      csQ <= 1'b1;
      ssiQ <= 1'b0;
      sinceFall <= 0;
      sinceCs <= 0;
      sinceRise <= 0;
      idleCnt <= 0;
      ssiCnt <= 0;
    end
    else
    begin
      sckQ <= spiSclk;
      csQ <= spiCsN;
      ssiQ <= serialAngleClock;
      sinceFall <= (sckQ && !spiSclk) ? 0 : sinceFall + 1;
      sinceCs <= (csQ && !spiCsN) ? 0 : sinceCs + 1;
      sinceRise <= (serialAngleClock && !ssiQ) ? 0 : sinceRise + 1;
      idleCnt <= (serialAngleClock != ssiQ) ? 0 : idleCnt + 1;
      if (serialAngleClock && !ssiQ)
        ssiCnt <= ssiCnt + 1;
      else if (idleCnt > TIMEOUT_CYCLES + 8)
        ssiCnt <= 0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_oe_frame; !spiCsN |-> spiMisoOe; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("miso not driven in frame");
  property p_oe_idle; spiCsN |-> !spiMisoOe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
  property p_miso_edge;
    $changed(spiMiso) && !spiCsN |-> $fell(spiSclk) || sinceFall < 4 || sinceCs < 8 || $fell(spiCsN);
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved off falling edge");
  property p_ssi_dummy; ssiCnt <= 1 |-> !serialAngleOut; endproperty
  a_ssi_dummy: assert property (p_ssi_dummy) else $error("data on dummy pulse");
  property p_ssi_rise; $rose(serialAngleOut) |-> sinceRise < 8; endproperty
  a_ssi_rise: assert property (p_ssi_rise) else $error("two-wire data not on rise");
  property p_ssi_pad; ssiCnt >= 14 && sinceRise > 5 |-> !serialAngleOut; endproperty
  a_ssi_pad: assert property (p_ssi_pad) else $error("low angle bits not zero");
  property p_ssi_release; idleCnt > TIMEOUT_CYCLES + 8 |-> !serialAngleOut; endproperty
  a_ssi_release: assert property (p_ssi_release) else $error("two-wire out after timeout");
  property p_dir_src; $changed(rotationCcw) |-> sinceCs < NVM_WAIT_CYCLES + 1000; endproperty
  a_dir_src: assert property (p_dir_src) else $error("direction changed with no frame");
endmodule

// ==== tb/asr_spi_master_model.sv ====
`timescale 1ns/1ps
module asr_spi_master_model
(
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic misoWire
);
  initial
  begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // A 160 ns link clock that stands still outside frames, after 1.2 us of idle select.
  task automatic xfer(input bit m3, input logic [15:0] cmd, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    spiSclk = m3;
    #1200 spiCsN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #80 spiSclk = 1'b0;
      spiMosi = cmd[15 - i];
      #80 spiSclk = 1'b1;
      rx[15 - i] = misoWire;
    end
    #80 spiSclk = m3;
    spiMosi = 1'b0;
    #80 spiCsN = 1'b1;
  endtask
endmodule

// ==== tb/asr_serial_readout_test.sv ====
`timescale 1ns/1ps
module asr_serial_readout_test
  import asr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] frontAngle = 16'habcd;
  logic fieldHighFlag = 1'b1;
  logic fieldLowFlag = 1'b0;
  logic serialAngleClock = 1'b0;
  logic [15:0] rx;
  wire logic spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe, serialAngleOut, rotationCcw;
  // The select-gated pull-down holds the released data line low.
  wire logic misoWire = spiMisoOe ? spiMiso : 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  asr_serial_readout #(.NVM_WAIT_CYCLES(2000), .TIMEOUT_CYCLES(100)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .frontAngle(frontAngle), .fieldHighFlag(fieldHighFlag), .fieldLowFlag(fieldLowFlag), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .serialAngleClock(serialAngleClock), .serialAngleOut(serialAngleOut), .rotationCcw(rotationCcw));
  asr_spi_master_model mst (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .misoWire(misoWire));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      $display("BAD %0t run did not finish", $time);
      final_report;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ang(input logic [15:0] a, input logic ccw);
    ang = (ccw ? 16'h0000 - a : a) & 16'hfff0;
  endfunction
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    mst.xfer(1'b0, {OPCODE_READ, a, 8'h00}, 16, rx);
    mst.xfer(1'b0, 16'h0000, 16, rx);
    chk(rx, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input int waitNs, input logic [15:0] exp);
    mst.xfer(1'b0, {OPCODE_WRITE, a, d}, 16, rx);
    #(waitNs);
    mst.xfer(1'b0, 16'h0000, 16, rx);
    chk(rx, exp);
  endtask
  task automatic ssi_read(input logic [15:0] newAngle, output logic [15:0] got);
    got = 16'h0000;
    for (int k = 1; k <= 17; k++)
    begin
      repeat (50) @(negedge ref_clk);
      serialAngleClock = 1'b1;
      if (k == 3)
        frontAngle = newAngle;
      repeat (50) @(negedge ref_clk);
      if (k >= 2)
        got = {got[14:0], serialAngleOut};
      serialAngleClock = 1'b0;
    end
    repeat (200) @(negedge ref_clk);
  endtask
  task automatic t_angle;
    fork
      mst.xfer(1'b0, 16'h0000, 16, rx);
      begin
        #1600;
        @(negedge ref_clk) frontAngle = 16'h1357;
      end
    join
    chk(rx, 16'habc0);
    mst.xfer(1'b1, 16'h0000, 16, rx);
    chk(rx, 16'h1350);
    mst.xfer(1'b0, 16'h0000, 8, rx);
    chk(rx, 16'h1300);
  endtask
  task automatic t_reg;
    rd(STATUS_ADDR, 16'h8000);
    @(negedge ref_clk) fieldHighFlag = 1'b0;
    fieldLowFlag = 1'b1;
    rd(STATUS_ADDR, 16'h4000);
    rd(5'h04, 16'hc000);
    rd(DIRECTION_ADDR, 16'h0000);
  endtask
  task automatic t_write;
    wr(DIRECTION_ADDR, 8'h80, 8000, 16'h8000);
    chk({15'h0000, rotationCcw}, 16'h0001);
    mst.xfer(1'b0, 16'h0000, 16, rx);
    chk(rx, ang(16'h1357, 1'b1));
    wr(5'h05, 8'h33, 0, 16'h0f00);
    #8000 rd(5'h05, 16'h3300);
    wr(DIRECTION_ADDR, 8'h00, 8000, 16'h0000);
  endtask
  task automatic t_bad;
    mst.xfer(1'b0, {OPCODE_WRITE, 5'h06, 8'h55}, 8, rx);
    #8000 rd(5'h06, 16'h1c00);
    mst.xfer(1'b0, {3'h7, 5'h06, 8'h55}, 16, rx);
    mst.xfer(1'b0, 16'h0000, 16, rx);
    chk(rx, ang(16'h1357, 1'b0));
    #8000 rd(5'h06, 16'h1c00);
  endtask
  task automatic t_ssi;
    @(negedge ref_clk) frontAngle = 16'h2468;
    #1200;
    ssi_read(16'h9999, rx);
    chk(rx, 16'h2460);
    repeat (10000) @(negedge ref_clk);
    ssi_read(16'h1111, rx);
    chk(rx, 16'h9990);
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    #1200;
    t_angle;
    t_reg;
    t_write;
    t_bad;
    t_ssi;
    final_report;
  end
endmodule
bind asr_serial_readout asr_serial_readout_props #(.NVM_WAIT_CYCLES(NVM_WAIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_props (.ref_clk(ref_clk), .reset_n(reset_n), .frontAngle(frontAngle), .fieldHighFlag(fieldHighFlag),
  .fieldLowFlag(fieldLowFlag), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
  .spiMisoOe(spiMisoOe), .serialAngleClock(serialAngleClock), .serialAngleOut(serialAngleOut),
  .rotationCcw(rotationCcw));
